// [ext_mem_bus_timing.sv]
//----------------------------------------------------------------------
// ext_mem_bus_timing
//----------------------------------------------------------------------
// Purpose: sequence one external data move with programmable timing
// Assumes: core holds request until done pulses; pins sit on core clock
// Notes:   data pins are three signals; output enable low means driving
module ext_mem_bus_timing #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_b,
   // special register port
   input  wire logic [7:0]        sfrAddr,
   input  wire logic [7:0]        sfrWdata,
   input  wire logic              sfrWrite,
   output logic [7:0]             sfrRdata,
   // core move request
   input  wire logic              moveReq,
   input  wire logic              moveWrite,
   input  wire logic [ADDR_W-1:0] moveAddr,
   input  wire logic [7:0]        moveWdata,
   output logic [7:0]             moveRdata,
   output logic                   moveDone,
   output logic                   moveBusy,
   // external memory pins
   output logic [ADDR_W-1:0]      memAddr,
   output logic [7:0]             memDataOut,
   output logic                   memDataOe_n,
   input  wire logic [7:0]        memDataIn,
   output logic                   memRd_n,
   output logic                   memWr_n,
   output logic                   memLatch
);
   import ext_mem_pkg::*;

   // refuse address widths that the pin register cannot serve
   if (ADDR_W < 8 || ADDR_W > 16) begin : gBadWidth
      $error("ADDR_W must be 8 to 16");
   end

   //------------------------------------------------------------------
   // registers
   //------------------------------------------------------------------
   logic [7:0]  ext_mem_timing_reg;
   logic [7:0]  ext_mem_config_reg;
   logic [7:0]  timingSnap_reg;
   logic [7:0]  configSnap_reg;
   phase_t      phase_reg;
   phase_t      phase_next;
   logic [4:0]  loadValue;
   logic        load;
   logic        phaseDone;
   logic [7:0]  dataSync1_reg;
   logic        strobeEnd_reg;
   logic [1:0]  setupField;
   logic [3:0]  strobeField;
   logic [1:0]  holdField;
   logic        muxMode;

   assign setupField  = timingSnap_reg[SETUP_MSB:SETUP_LSB];     // [RULE9]
   assign strobeField = timingSnap_reg[STROBE_MSB:STROBE_LSB];   // [RULE8]
   assign holdField   = timingSnap_reg[HOLD_MSB:HOLD_LSB];       // [RULE10]
   // in idle the snapshot is not yet taken, so the live config decides
   assign muxMode     = (phase_reg == ST_IDLE) ? ext_mem_config_reg[MUX_MODE_BIT]
                                               : configSnap_reg[MUX_MODE_BIT];

   // register writes; slowest timing after reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ext_mem_timing_reg <= TIMING_RESET;                     // [RULE6]
         ext_mem_config_reg <= CONFIG_RESET;
      end else if (sfrWrite) begin
         if (sfrAddr == TIMING_ADDR) begin
            ext_mem_timing_reg <= sfrWdata;                      // [RULE1]
         end
         if (sfrAddr == CONFIG_ADDR) begin
            ext_mem_config_reg <= sfrWdata;
         end
      end
   end

   // registered read port; unmapped addresses read zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sfrRdata <= 8'h00;
      end else if (sfrAddr == TIMING_ADDR) begin
         sfrRdata <= ext_mem_timing_reg;
      end else if (sfrAddr == CONFIG_ADDR) begin
         sfrRdata <= {ext_mem_config_reg[7:1], ext_mem_config_reg[0]};
      end else begin
         sfrRdata <= 8'h00;
      end
   end

   // snapshot timing at move start so a mid-move write cannot tear a phase
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         timingSnap_reg <= TIMING_RESET;
         configSnap_reg <= CONFIG_RESET;
      end else if (phase_reg == ST_IDLE && moveReq && !moveDone) begin
         timingSnap_reg <= ext_mem_timing_reg;
         configSnap_reg <= ext_mem_config_reg;
      end
   end

   //------------------------------------------------------------------
   // phase sequencing
   //------------------------------------------------------------------
   // each load value is the phase length minus one, the counter then
   // runs down to zero; the first setup cycle and the one tail cycle plus
   // two request/finish cycles make up the fixed overhead of four
   always_comb begin
      phase_next = phase_reg;
      load       = 1'b0;
      loadValue  = 5'h00;
      unique case (phase_reg)
         ST_IDLE: begin
            // the done cycle refuses a request still held from the last move
            if (moveReq && !moveDone) begin
               load = 1'b1;
               if (muxMode) begin
                  phase_next = ST_LATCH;                         // [RULE4]
                  loadValue  = 5'(ext_mem_config_reg[LATCH_MSB:LATCH_LSB]) + LATCH_MIN
                               - 5'h01;                          // [RULE5]
               end else begin
                  phase_next = ST_SETUP;
                  loadValue  = 5'h00;
               end
            end
         end
         ST_LATCH: begin
            if (phaseDone) begin
               phase_next = ST_SETUP;
               load       = 1'b1;
            end
         end
         ST_SETUP: begin
            // setup takes the one overhead cycle plus code cycles
            if (phaseDone) begin
               load       = 1'b1;
               if (setupField == 2'b00) begin
                  phase_next = ST_STROBE;
                  loadValue  = 5'(strobeField);                  // [RULE8]
               end else begin
                  phase_next = ST_SETUP;
                  loadValue  = 5'(setupField) - 5'h01;           // [RULE9]
               end
            end
         end
         ST_STROBE: begin
            if (phaseDone) begin
               load       = 1'b1;
               phase_next = (holdField == 2'b00) ? ST_TAIL : ST_HOLD;
               loadValue  = (holdField == 2'b00) ? 5'h00 : 5'(holdField) - 5'h01; // [RULE10]
            end
         end
         ST_HOLD: begin
            if (phaseDone) begin
               phase_next = ST_TAIL;
               load       = 1'b1;
            end
         end
         ST_TAIL: begin
            if (phaseDone) begin
               phase_next = ST_IDLE;
            end
         end
         default: begin
            phase_next = ST_IDLE;
         end
      endcase
   end

   // the setup phase is re-entered once with its remaining count; a flag
   // marks the second pass so it falls through to the strobe next time
   logic setupPass_reg;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         setupPass_reg <= 1'b0;
      end else if (phase_reg == ST_SETUP && phaseDone) begin
         setupPass_reg <= ~setupPass_reg & (setupField != 2'b00);
      end
   end

   phase_t phaseFix;
   logic [4:0] loadFix;
   always_comb begin
      phaseFix = phase_next;
      loadFix  = loadValue;
      if (phase_reg == ST_SETUP && phaseDone && setupPass_reg) begin
         phaseFix = ST_STROBE;
         loadFix  = 5'(strobeField);                             // [RULE2]
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= ST_IDLE;
      end else begin
         phase_reg <= phaseFix;
      end
   end

   phase_counter #(.WIDTH(5)) timer (
      .clock     (clock),
      .rst_b     (rst_b),
      .load      (load),
      .loadValue (loadFix),
      .done      (phaseDone)
   );

   //------------------------------------------------------------------
   // pins and core answer
   //------------------------------------------------------------------
   // read data passes two flops since the memory is off-chip: the first
   // every cycle, the second (moveRdata) two edges after the last strobe
   // cycle, so a released bus never reaches the core
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dataSync1_reg <= 8'h00;
         strobeEnd_reg <= 1'b0;
      end else begin
         dataSync1_reg <= memDataIn;
         strobeEnd_reg <= (phase_reg == ST_STROBE) && phaseDone;
      end
   end

   // pins follow the next phase so they change with the phase edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         memAddr     <= '0;
         memDataOut  <= 8'h00;
         memDataOe_n <= 1'b1;
         memRd_n     <= 1'b1;
         memWr_n     <= 1'b1;
         memLatch    <= 1'b0;
         moveDone    <= 1'b0;
         moveBusy    <= 1'b0;
         moveRdata   <= 8'h00;
      end else begin
         moveDone <= (phase_reg == ST_TAIL) && phaseDone;        // [RULE3]
         moveBusy <= (phaseFix != ST_IDLE);
         memLatch <= muxMode && (phaseFix == ST_LATCH);                // [RULE5]
         memRd_n  <= !((phaseFix == ST_STROBE) && !moveWrite);
         memWr_n  <= !((phaseFix == ST_STROBE) && moveWrite);
         if (phase_reg == ST_IDLE && moveReq && !moveDone) begin
            memAddr    <= moveAddr;                              // [RULE7]
            memDataOut <= moveWdata;
         end
         // write data stands from latch or setup through hold on its own pins
         memDataOe_n <= !(moveWrite && phaseFix != ST_IDLE && phaseFix != ST_TAIL);
         if (strobeEnd_reg && !moveWrite) begin
            moveRdata <= dataSync1_reg;                          // [RULE11]
         end
      end
   end
endmodule

// [ext_mem_monitor.sv]
// ----------
// Purpose: port checker for the bus timing block
// Assumes: no register write while a move runs
// Notes:   shadows the timing and config registers from writes
// ----------
module ext_mem_monitor #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic              clock,
   input wire logic              rst_b,
   // register port and core
   input wire logic [7:0]        sfrAddr,
   input wire logic [7:0]        sfrWdata,
   input wire logic              sfrWrite,
   input wire logic              moveReq,
   input wire logic              moveDone,
   input wire logic              moveBusy,
   // pins
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic              memDataOe_n,
   input wire logic              memRd_n,
   input wire logic              memWr_n,
   input wire logic              memLatch
);
   import ext_mem_pkg::*;
   logic [7:0] timReg, cfgReg, snap;
   logic [5:0] busyCnt, strbCnt, expTotal;
   // shadow copies, timing taken while a request waits in idle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         timReg <= TIMING_RESET;
         cfgReg <= CONFIG_RESET;
         snap   <= TIMING_RESET;
      end else begin
         if (sfrWrite && sfrAddr == TIMING_ADDR) timReg <= sfrWdata;
         if (sfrWrite && sfrAddr == CONFIG_ADDR) cfgReg <= sfrWdata;
         if (moveReq && !moveBusy && !moveDone) snap <= timReg;
      end
   end
   // run lengths of the move and of the strobe
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busyCnt <= 6'h00;
         strbCnt <= 6'h00;
      end else begin
         busyCnt <= (moveBusy || moveDone) ? busyCnt + 6'h01 : 6'h00;
         strbCnt <= (!memRd_n || !memWr_n) ? strbCnt + 6'h01 : 6'h00;
      end
   end
   assign expTotal = 6'(snap[7:6]) + 6'(snap[5:2]) + 6'(snap[1:0]) + 6'h05
                   + (cfgReg[4] ? 6'(cfgReg[1:0]) + 6'h02 : 6'h00);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // busy run plus the request cycle and the done cycle
   property p_total; moveDone |-> busyCnt + 6'h02 == expTotal; endproperty
   a_total: assert property (p_total) else $error("move length wrong");
   property p_strobe; $rose(memRd_n) || $rose(memWr_n) |-> strbCnt == 6'(snap[5:2]) + 6'h01;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe width wrong");
   property p_one_strobe; memRd_n || memWr_n; endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
   property p_hold_addr; $rose(memRd_n) || $rose(memWr_n) |-> $stable(memAddr); endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("address moved");
   property p_no_latch; !cfgReg[4] |-> !memLatch; endproperty
   a_no_latch: assert property (p_no_latch) else $error("latch in plain mode");
   property p_wr_drive; !memWr_n |-> !memDataOe_n; endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write not driven");
   property p_rd_free; !memRd_n |-> memDataOe_n; endproperty
   a_rd_free: assert property (p_rd_free) else $error("read while driving");
   property p_done; moveDone |=> !moveDone && !moveBusy; endproperty
   a_done: assert property (p_done) else $error("done not a pulse");
   cover property (moveDone && cfgReg[4]);
   cover property (moveDone && snap == 8'h00);
   cover property ($rose(memWr_n));
endmodule

bind ext_mem_bus_timing ext_mem_monitor #(.ADDR_W(ADDR_W)) mon (.clock, .rst_b,
   .sfrAddr, .sfrWdata, .sfrWrite, .moveReq, .moveDone, .moveBusy, .memAddr,
   .memDataOe_n, .memRd_n, .memWr_n, .memLatch);

// [ext_mem_partner.sv]
// ----------
// Purpose: behavioural parallel memory on the pins
// Assumes: 256 bytes decoded from the low address
// Notes:   LAG delays read data into the strobe
// ----------
module ext_mem_partner #(
   parameter int ADDR_W = 16,
   parameter int LAG    = 0
) (
   // pins
   input wire logic              clock,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic [7:0]        memDataOut,
   input wire logic              memRd_n,
   input wire logic              memWr_n,
   output logic [7:0]            memDataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:255];
   logic [7:0] last = 8'h00;
   int         lagCnt = 0;
   // store while the write strobe is low
   always @(posedge clock) begin
      if (!memWr_n) mem[memAddr[7:0]] <= memDataOut;
      if (!memRd_n) last <= mem[memAddr[7:0]];
      lagCnt <= memRd_n ? 0 : lagCnt + 1;
   end
   // a released bus shows inverted data so stale values never pass
   assign memDataIn = (!memRd_n && lagCnt >= LAG) ? mem[memAddr[7:0]] : ~last;
endmodule

// [ext_mem_pkg.sv]
//----------------------------------------------------------------------
// ext_mem_pkg
//----------------------------------------------------------------------
// Purpose: constants for the external memory bus timing block
// Assumes: 8-bit special register port, one core clock
// Notes:   offsets are special-register addresses
//
// Operation
// RULE1: setup, hold, strobe width and latch pulse width are counted in whole core clock periods.
// RULE2: an off-chip move lasts four cycles plus the setup, strobe and hold cycles selected.
// RULE3: non-multiplexed with minimum settings a move completes in five cycles.
// RULE4: multiplexed mode adds at least two latch cycles to every off-chip move.
// RULE5: the latch pulse width in multiplexed mode comes from config register bits 1 to 0.
// RULE6: the timing register resets to all ones, giving the slowest timing.
// RULE7: non-multiplexed mode drives address and data on separate pins.
// RULE8: strobe width field bits 5 to 2 give code plus one cycles of strobe.
// RULE9: address setup field bits 7 to 6 give code cycles of setup.
// RULE10: address hold field bits 1 to 0 give code cycles of hold after the strobe.
// RULE11: the external memory answers within the programmed strobe window.
package ext_mem_pkg;
   localparam logic [7:0] TIMING_ADDR      = 8'ha1;
   localparam logic [7:0] CONFIG_ADDR      = 8'ha3;
   localparam logic [7:0] TIMING_RESET     = 8'hff;
   localparam logic [7:0] CONFIG_RESET     = 8'h03;
   localparam int         SETUP_MSB        = 7;
   localparam int         SETUP_LSB        = 6;
   localparam int         STROBE_MSB       = 5;
   localparam int         STROBE_LSB       = 2;
   localparam int         HOLD_MSB         = 1;
   localparam int         HOLD_LSB         = 0;
   localparam int         MUX_MODE_BIT     = 4;
   localparam int         LATCH_MSB        = 1;
   localparam int         LATCH_LSB        = 0;
   localparam logic [4:0] FIXED_OVERHEAD   = 5'h04;
   localparam logic [4:0] LATCH_MIN        = 5'h02;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_LATCH  = 3'b001,
      ST_SETUP  = 3'b010,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b100,
      ST_TAIL   = 3'b101
   } phase_t;
endpackage

// [phase_counter.sv]
//----------------------------------------------------------------------
// phase_counter
//----------------------------------------------------------------------
// Purpose: down counter that times one bus phase
// Assumes: load and count never in the same cycle as reset release
// Notes:   done is high while the count is zero
module phase_counter #(
   parameter int WIDTH = 5
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  done
);
   logic [WIDTH-1:0] count_reg;

   // load wins over count so a new phase never inherits a stale tail
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= loadValue;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   assign done = (count_reg == '0);
endmodule

// [tb.sv]
// ----------
// Purpose: register and move scenarios for the bus timing block
// Assumes: one move at a time, registers written between moves
// Notes:   move length counts cycles from the request through done
// ----------
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ext_mem_pkg::*;
   logic        clock, rst_b, sfrWrite, moveReq, moveWrite, moveDone, moveBusy;
   logic [7:0]  sfrAddr, sfrWdata, sfrRdata, moveWdata, moveRdata, memDataOut, memDataIn;
   logic [15:0] moveAddr, memAddr;
   logic        memDataOe_n, memRd_n, memWr_n, memLatch;
   logic [7:0]  rd, t;
   logic [7:0]  tims [11] = '{8'hff, 8'h00, 8'h40, 8'h80, 8'hc0, 8'h04, 8'h3c, 8'h01,
                              8'h02, 8'h03, 8'h9b};
   int          mismatches = 0, num_checks = 0, n, strobe, strbRun = 0, latchHits;
   ext_mem_bus_timing #(.ADDR_W(16)) DUT (.clock, .rst_b, .sfrAddr, .sfrWdata, .sfrWrite,
      .sfrRdata, .moveReq, .moveWrite, .moveAddr, .moveWdata, .moveRdata, .moveDone,
      .moveBusy, .memAddr, .memDataOut, .memDataOe_n, .memDataIn, .memRd_n, .memWr_n,
      .memLatch);
   ext_mem_partner #(.ADDR_W(16)) mem (.clock, .memAddr, .memDataOut, .memRd_n, .memWr_n,
      .memDataIn);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // strobe width and latch activity seen on the pins
   always @(posedge clock) begin
      if (memLatch === 1'b1) latchHits++;
      if (memRd_n === 1'b0 || memWr_n === 1'b0) strbRun++;
      else if (strbRun != 0) begin
         strobe = strbRun;
         strbRun = 0;
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfrAddr <= a;
      sfrWdata <= d;
      sfrWrite <= 1'b1;
      @(posedge clock);
      sfrWrite <= 1'b0;
   endtask
   // read data is registered one cycle after the address
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfrAddr <= a;
      repeat (2) @(posedge clock);
      d = sfrRdata;
   endtask
   // request held until done, then dropped on that edge
   task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d);
      int i;
      n = 0;
      latchHits = 0;
      strobe = 0;
      @(posedge clock);
      moveReq <= 1'b1;
      moveWrite <= w;
      moveAddr <= a;
      moveWdata <= d;
      for (i = 0; i < 100 && moveDone !== 1'b1; i++) begin
         @(posedge clock);
         if (moveReq === 1'b1 || moveBusy === 1'b1 || moveDone === 1'b1) n++;
      end
      if (i == 100) begin
         mismatches++;
         end_of_test();
      end
      rd = moveRdata;
      moveReq <= 1'b0;
      @(posedge clock);
   endtask
   function automatic int span(input logic [7:0] x);
      return 5 + x[7:6] + x[5:2] + x[1:0];
   endfunction
   initial begin
      {rst_b, sfrWrite, moveReq, moveWrite} = 4'h0;
      {sfrAddr, sfrWdata, moveWdata, moveAddr} = 40'h0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      sfr_rd(TIMING_ADDR, rd); `CHK(rd, TIMING_RESET)
      sfr_rd(CONFIG_ADDR, rd); `CHK(rd, CONFIG_RESET)
      // every field at its ends and some mixtures, write then read back
      foreach (tims[k]) begin
         t = tims[k];
         sfr_wr(TIMING_ADDR, t);
         sfr_rd(TIMING_ADDR, rd); `CHK(rd, t)
         move(1'b1, {8'h01, t}, t ^ 8'h5a); `CHK(n, span(t))
         `CHK(strobe, t[5:2] + 1)
         `CHK(latchHits, 0)
         move(1'b0, {8'h01, t}, 8'h00); `CHK(rd, t ^ 8'h5a)
         `CHK(n, span(t))
         if (t == 8'h00) `CHK(n, 5)
      end
      // multiplexed mode adds the latch phase, at minimum timing
      sfr_wr(TIMING_ADDR, 8'h00);
      for (int c = 0; c < 4; c++) begin
         sfr_wr(CONFIG_ADDR, 8'h10 | 8'(c));
         move(1'b1, 16'h0200 + 16'(c), 8'(c) + 8'ha0); `CHK(n, 7 + c)
         `CHK(latchHits, c + 2)
         move(1'b0, 16'h0200 + 16'(c), 8'h00); `CHK(rd, 8'(c) + 8'ha0)
      end
      sfr_wr(CONFIG_ADDR, 8'h00);
      sfr_wr(8'h55, 8'h7e);
      sfr_rd(TIMING_ADDR, rd); `CHK(rd, 8'h00)
      sfr_rd(8'h55, rd); `CHK(rd, 8'h00)
      // reset between moves returns the slowest timing
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      sfr_rd(TIMING_ADDR, rd); `CHK(rd, 8'hff)
      move(1'b0, 16'h01ff, 8'h00); `CHK(n, 26)
      `CHK(rd, 8'ha5)
      end_of_test();
   end
endmodule
